/* design/discovery_table_read.sv */
// Purpose: Discovery parameter table read command inside a serial flash
// Assumes: Serial clock well below clk/4; pins sampled through 2 flops
// Notes:   Command and address always use line 0; data lanes follow mode
`default_nettype none

module discovery_table_read (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Serial bus pins
    input  wire logic            spi_sclk,
    input  wire logic            spi_cs_n,
    input  wire logic [3:0]      serial_io_in,
    output logic      [3:0]      serial_io_out,
    output logic      [3:0]      serial_io_oe,
    // Protocol strap
    input  wire sfdp_pkg::proto_t proto_mode,
    // Status
    output logic                 busy
);
    import sfdp_pkg::*;

    // ==========================================
    // State encoding
    // ==========================================
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_DUMMY  = 3'b011,
        ST_DATA   = 3'b100,
        ST_IGNORE = 3'b101
    } state_t;

    // ==========================================
    // Functions
    // ==========================================
    function automatic logic [7:0] table_byte(input logic [TABLE_AW-1:0] a);
        logic [7:0] b;
        b = BLANK_BYTE;
        case (a)
            11'h000: b = 8'h53; // R07
            11'h001: b = 8'h46; // R07
            11'h002: b = 8'h44; // R07
            11'h003: b = 8'h50; // R07
            11'h004: b = 8'h00; // R07
            11'h005: b = 8'h01; // R07
            11'h006: b = 8'h00; // R08
            11'h007: b = 8'hff; // R08
            11'h008: b = 8'h00; // R09
            11'h009: b = 8'h00; // R09
            11'h00a: b = 8'h01; // R09
            11'h00b: b = 8'h09; // R09
            11'h00c: b = 8'h30; // R09
            11'h00d: b = 8'h00; // R09
            11'h00e: b = 8'h00; // R09
            11'h00f: b = 8'hff; // R09
            11'h030: b = 8'he5; // R11
            11'h031: b = 8'h20; // R12
            11'h032: b = 8'hf1; // R13
            11'h033: b = 8'hff; // R13
            11'h034: b = 8'hff; // R14
            11'h035: b = 8'hff; // R14
            11'h036: b = 8'hff; // R14
            11'h037: b = 8'h07; // R14
            11'h038: b = 8'h29; // R15
            11'h039: b = 8'heb; // R15
            11'h03a: b = 8'h27; // R16
            11'h03b: b = 8'h6b; // R16
            11'h03c: b = 8'h08; // R17
            11'h03d: b = 8'h3b; // R17
            11'h03e: b = 8'h27; // R18
            11'h03f: b = 8'hbb; // R18
            11'h040: b = 8'hff; // R19
            11'h046: b = 8'h28; // R20
            11'h047: b = 8'hbb; // R20
            11'h04a: b = 8'h2a; // R21
            11'h04b: b = 8'heb; // R21
            11'h04c: b = 8'h0c; // R22
            11'h04d: b = 8'h20; // R22
            11'h04e: b = 8'h10; // R22
            11'h04f: b = 8'hd8; // R22
            11'h050: b = 8'h00; // R22
            11'h051: b = 8'h00; // R22
            11'h052: b = 8'h00; // R22
            11'h053: b = 8'h00; // R22
            // 10h-2Fh, 41h-45h, 48h-49h and 54h upward read blank
            default: b = BLANK_BYTE; // R10 R19 R20 R25
        endcase
        return b;
    endfunction

    // Last beat index within one byte for the active lane width
    function automatic logic [2:0] last_beat(input proto_t m);
        logic [2:0] r;
        r = 3'h7;
        case (m)
            PROTO_DUAL: r = 3'h3;
            PROTO_QUAD: r = 3'h1;
            default:    r = 3'h7;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] lane_oe(input proto_t m);
        logic [3:0] r;
        r = OE_EXT;
        case (m)
            PROTO_DUAL: r = OE_DUAL;
            PROTO_QUAD: r = OE_QUAD;
            default:    r = OE_EXT;
        endcase
        return r;
    endfunction

    // ==========================================
    // Input synchronisers
    // ==========================================
    logic       sclk_s1_q;
    logic       sclk_s2_q;
    logic       sclk_s3_q;
    logic       cs_s1_q;
    logic       cs_s2_q;
    logic [3:0] io_s1_q;
    logic [3:0] io_s2_q;
    proto_t     mode_s1_q;
    proto_t     mode_s2_q;

    // Reset values idle the bus: clock low, select high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            io_s1_q   <= 4'h0;
            io_s2_q   <= 4'h0;
            mode_s1_q <= PROTO_EXT;
            mode_s2_q <= PROTO_EXT;
        end else begin
            sclk_s1_q <= spi_sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q   <= spi_cs_n;
            cs_s2_q   <= cs_s1_q;
            io_s1_q   <= serial_io_in;
            io_s2_q   <= io_s1_q;
            mode_s1_q <= proto_mode;
            mode_s2_q <= mode_s1_q;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic selected;

    assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
    assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
    assign selected  = ~cs_s2_q;

    // ==========================================
    // Frame registers
    // ==========================================
    state_t                state_q;
    state_t                state_d;
    logic [CNT_W-1:0]      cnt_q;
    logic [7:0]            cmd_sh_q;
    logic [23:0]           addr_sh_q;
    logic [TABLE_AW-1:0]   ptr_q;
    logic [7:0]            out_sh_q;
    logic [2:0]            beat_q;
    proto_t                mode_q;
    logic [4:0]            dummy_last;
    logic [7:0]            cmd_next;
    logic [23:0]           addr_next;
    logic [7:0]            byte_now;

    assign cmd_next   = {cmd_sh_q[6:0], io_s2_q[0]};
    assign addr_next  = {addr_sh_q[22:0], io_s2_q[0]};
    assign dummy_last = (mode_q == PROTO_QUAD) ? DUMMY_QUAD - 5'h01
                                               : DUMMY_STD - 5'h01; // R02
    // A fresh byte is fetched on the first beat of each byte
    assign byte_now   = (beat_q == 3'h0) ? table_byte(ptr_q) : out_sh_q;

    // ==========================================
    // Sequencer
    // ==========================================
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (selected) begin
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                if (sclk_rise && cnt_q == CMD_LAST) begin
                    if (cmd_next == OP_DISCOVERY) begin // R24
                        state_d = ST_ADDR;
                    end else begin
                        state_d = ST_IGNORE;
                    end
                end
            end
            ST_ADDR: begin
                if (sclk_rise && cnt_q == ADDR_LAST) begin // R01
                    state_d = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                if (sclk_rise && cnt_q == dummy_last) begin // R02
                    state_d = ST_DATA;
                end
            end
            // Stays in data until deselect; no burst length applies
            ST_DATA:   state_d = ST_DATA; // R06
            ST_IGNORE: state_d = ST_IGNORE;
            default:   state_d = ST_IDLE;
        endcase
        if (!selected) begin
            state_d = ST_IDLE; // R05
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Protocol is frozen per frame so a strap change cannot split a byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= PROTO_EXT;
        end else if (state_q == ST_IDLE) begin
            mode_q <= mode_s2_q;
        end
    end

    // ==========================================
    // Bit counter
    // ==========================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (state_q != state_d) begin
            cnt_q <= '0;
        end else if (sclk_rise) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // ==========================================
    // Command and address capture
    // ==========================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_sh_q <= 8'h00;
        end else if (state_q == ST_CMD && sclk_rise) begin
            cmd_sh_q <= cmd_next; // R01
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_sh_q <= 24'h000000;
        end else if (state_q == ST_ADDR && sclk_rise) begin
            addr_sh_q <= addr_next; // R23
        end
    end

    // ==========================================
    // Table pointer
    // ==========================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_q <= '0;
        end else if (state_q == ST_ADDR && sclk_rise && cnt_q == ADDR_LAST) begin
            ptr_q <= addr_next[TABLE_AW-1:0]; // R03 R25
        end else if (state_q == ST_DATA && sclk_fall && beat_q == 3'h0) begin
            // Natural overflow of the 11-bit pointer gives the wrap
            ptr_q <= ptr_q + 11'h001; // R03 R04
        end
    end

    // ==========================================
    // Output shifter
    // ==========================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            beat_q <= 3'h0;
        end else if (state_q != ST_DATA) begin
            beat_q <= 3'h0;
        end else if (sclk_fall) begin
            if (beat_q == last_beat(mode_q)) begin
                beat_q <= 3'h0;
            end else begin
                beat_q <= beat_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_sh_q <= 8'h00;
        end else if (state_q == ST_DATA && sclk_fall) begin
            case (mode_q)
                PROTO_DUAL: out_sh_q <= {byte_now[5:0], 2'b00};
                PROTO_QUAD: out_sh_q <= {byte_now[3:0], 4'h0};
                default:    out_sh_q <= {byte_now[6:0], 1'b0};
            endcase
        end
    end

    // Data changes on the falling edge so the host samples it stable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_io_out <= 4'h0;
        end else if (state_q == ST_DATA && sclk_fall) begin
            case (mode_q)
                PROTO_DUAL: serial_io_out <= {2'b00, byte_now[7:6]};
                PROTO_QUAD: serial_io_out <= byte_now[7:4];
                default:    serial_io_out <= {2'b00, byte_now[7], 1'b0};
            endcase
        end
    end

    // ==========================================
    // Output enables and status
    // ==========================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_io_oe <= OE_NONE;
        end else if (!selected || state_q != ST_DATA) begin
            serial_io_oe <= OE_NONE; // R05
        end else if (sclk_fall) begin
            serial_io_oe <= lane_oe(mode_q);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_d == ST_ADDR) || (state_d == ST_DUMMY)
                 || (state_d == ST_DATA);
        end
    end

endmodule

`default_nettype wire

/* design/sfdp_pkg.sv */
// Purpose: Shared constants for the discovery table read block
// Assumes: One 50 MHz clock; serial bus pins arrive asynchronously
// Notes:   Table contents live in the design file's lookup function
//
// What this block does
// R01 - Command byte, then three address bytes on line 0
// R02 - Dummy clocks: 8 extended/dual, 10 quad
// R03 - Output starts at address, then advances per byte
// R04 - Pointer wraps to zero past 2048 bytes
// R05 - Chip select high stops output, abandons command
// R06 - Always continuous read, burst wrap ignored
// R07 - Bytes 00h-05h: signature and revision 1.0
// R08 - Byte 06h header count 00h, 07h FFh
// R09 - Bytes 08h-0Fh: parameter header, pointer 30h
// R10 - Bytes 10h through 2Fh read FFh
// R11 - Byte 30h erase size, granularity, unused ones
// R12 - Byte 31h holds 4KB erase opcode 20h
// R13 - Bytes 32h-33h fast read support flags, FFh
// R14 - Bytes 34h-37h flash size, low byte first
// R15 - Bytes 38h-39h quad io read timing, EBh
// R16 - Bytes 3Ah-3Bh quad output read timing, 6Bh
// R17 - Bytes 3Ch-3Dh dual output read timing, 3Bh
// R18 - Bytes 3Eh-3Fh dual io read timing, BBh
// R19 - Byte 40h all ones, 41h-45h FFh
// R20 - Bytes 46h-49h dual protocol read timing
// R21 - Bytes 4Ah-4Bh quad protocol read timing
// R22 - Bytes 4Ch-53h erase type size/opcode pairs
// R23 - Address bits sampled on rising serial clock
// R24 - Opcode 5Ah selects this command
// R25 - Undescribed bytes FFh; address above bit 10 ignored
`default_nettype none

package sfdp_pkg;

    // ==========================================
    // Protocol and command
    // ==========================================
    typedef enum logic [1:0] {
        PROTO_EXT  = 2'b00,
        PROTO_DUAL = 2'b01,
        PROTO_QUAD = 2'b10
    } proto_t;

    localparam logic [7:0] OP_DISCOVERY = 8'h5a;

    // ==========================================
    // Frame geometry
    // ==========================================
    localparam int         TABLE_AW     = 11;
    localparam int         CNT_W        = 5;
    localparam logic [4:0] CMD_LAST     = 5'h07;
    localparam logic [4:0] ADDR_LAST    = 5'h17;
    localparam logic [4:0] DUMMY_STD    = 5'h08;
    localparam logic [4:0] DUMMY_QUAD   = 5'h0a;
    localparam logic [2:0] BEATS_EXT    = 3'h0;
    localparam logic [2:0] BEATS_DUAL   = 3'h4;
    localparam logic [2:0] BEATS_QUAD   = 3'h6;
    localparam logic [7:0] BLANK_BYTE   = 8'hff;

    // ==========================================
    // Output lane enables
    // ==========================================
    localparam logic [3:0] OE_EXT       = 4'h2;
    localparam logic [3:0] OE_DUAL      = 4'h3;
    localparam logic [3:0] OE_QUAD      = 4'hf;
    localparam logic [3:0] OE_NONE      = 4'h0;

endpackage

`default_nettype wire

/* bench/discovery_checker.sv */
// Purpose: Protocol assertions for the discovery table read block
// Assumes: Pins watched raw on clk; serial clock near 160 ns
// Notes:   Raw edge counters leave room for the design's synchroniser lag
`default_nettype none

module discovery_checker
    import sfdp_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Serial bus pins
    input  wire logic             spi_sclk,
    input  wire logic             spi_cs_n,
    input  wire logic [3:0]       serial_io_in,
    input  wire logic [3:0]       serial_io_out,
    input  wire logic [3:0]       serial_io_oe,
    // Strap and status
    input  wire sfdp_pkg::proto_t proto_mode,
    input  wire logic             busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_q;
    logic [11:0] rise_q;
    logic [11:0] fall_q;

    // ==========================================
    // Raw serial clock edges within a frame
    // ==========================================
    always_ff @(posedge clk) begin
        sclk_q <= spi_sclk;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || spi_cs_n) begin
            rise_q <= 12'h0;
            fall_q <= 12'h0;
        end else begin
            rise_q <= rise_q + {11'h0, spi_sclk & ~sclk_q};
            fall_q <= fall_q + {11'h0, ~spi_sclk & sclk_q};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================
    // Assertions
    // ==========================================
    reset_quiet_a: assert property ($fell(sys_rst) |-> serial_io_oe == OE_NONE && !busy)
        else $error("outputs not quiet after reset");
    busy_start_a: assert property ($rose(busy) |-> rise_q == 12'h8)
        else $error("busy rose away from the eighth command bit");
    dummy_count_a: assert property ($rose(serial_io_oe != OE_NONE) |->
        fall_q == (proto_mode == PROTO_QUAD ? 12'h2a : 12'h28))
        else $error("data began after wrong dummy count");
    lane_mode_a: assert property ((serial_io_oe != OE_NONE) |-> serial_io_oe ==
        (proto_mode == PROTO_QUAD ? OE_QUAD : proto_mode == PROTO_DUAL ? OE_DUAL : OE_EXT))
        else $error("driven lanes do not match protocol");
    data_hold_a: assert property ($rose(spi_sclk) && serial_io_oe != OE_NONE |->
        ##2 ($stable(serial_io_out))[*4])
        else $error("data moved while serial clock high");
    deselect_stop_a: assert property ($rose(spi_cs_n) |-> ##[1:6] serial_io_oe == OE_NONE)
        else $error("lanes still driven after deselect");
    idle_quiet_a: assert property (spi_cs_n [*6] |-> serial_io_oe == OE_NONE)
        else $error("lanes driven while deselected");
    idle_busy_a: assert property (spi_cs_n [*8] |-> !busy)
        else $error("busy while deselected");
endmodule

bind discovery_table_read discovery_checker chk (
    .clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .serial_io_in(serial_io_in), .serial_io_out(serial_io_out),
    .serial_io_oe(serial_io_oe), .proto_mode(proto_mode), .busy(busy));

`default_nettype wire

/* bench/spi_host.sv */
// Purpose: Serial bus host model driving discovery reads
// Assumes: Mode 0 clock, 4 clk low and 4 clk high
// Notes:   Undriven lanes 3:1 toggle every serial clock so stale data never matches
`default_nettype none

module spi_host
    import sfdp_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Serial bus
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      drv,
    input  wire logic [3:0] line,
    input  wire logic [3:0] oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    logic       saw_oe;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv = 4'h0;
        saw_oe = 1'b0;
    end

    always @(posedge clk) begin
        if (!cs_n && oe != 4'h0) saw_oe = 1'b1;
    end

    // ==========================================
    // One serial clock; sample late in high half
    // ==========================================
    task automatic tick(input logic d0, output logic [3:0] s);
        @(negedge clk) sclk = 1'b0;
        drv = {~drv[3:1], d0};
        repeat (3) @(negedge clk);
        @(negedge clk) sclk = 1'b1;
        repeat (3) @(negedge clk);
        s = line;
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] a, input proto_t m,
                         input int nclk);
        logic [31:0] sh;
        logic [3:0]  s;
        logic [7:0]  b;
        int          k;
        int          w;
        sh = {op, a};
        b = 8'h0;
        rx_q.delete();
        w = (m == PROTO_QUAD) ? 4 : (m == PROTO_DUAL) ? 2 : 1;
        repeat (6) @(negedge clk);
        cs_n = 1'b0;
        saw_oe = 1'b0;
        for (k = 0; k < 32; k++) tick(sh[31-k], s);
        for (k = 0; k < ((m == PROTO_QUAD) ? 10 : 8); k++) tick(1'b0, s);
        for (k = 0; k < nclk; k++) begin
            tick(1'b0, s);
            b = (w == 4) ? {b[3:0], s} : (w == 2) ? {b[5:0], s[1:0]} : {b[6:0], s[1]};
            if ((k + 1) % (8 / w) == 0) rx_q.push_back(b);
        end
        @(negedge clk) sclk = 1'b0;
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
    endtask
endmodule

`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the discovery table read block
// Assumes: 50 MHz clk, 160 ns serial clock from the host model
// Notes:   Random frames use a fixed seed; table expected from a constant
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sfdp_pkg::*;

    localparam logic [8*84-1:0] TBL = {
        64'h53_46_44_50_00_01_00_ff, 64'h00_00_01_09_30_00_00_ff, {32{8'hff}},
        64'he5_20_f1_ff_ff_ff_ff_07, 64'h29_eb_27_6b_08_3b_27_bb,
        64'hff_ff_ff_ff_ff_ff_28_bb, 64'hff_ff_2a_eb_0c_20_10_d8, 32'h0};

    logic       clk;
    logic       sys_rst;
    logic       sclk;
    logic       cs_n;
    logic       busy;
    logic [3:0] drv;
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] lane;
    proto_t     mode;
    int         err_count;
    int         checks;
    int         seed;
    int         i;

    // Each lane carries whoever drives it
    assign lane = (oe & out) | (~oe & drv);

    discovery_table_read dut (
        .clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .serial_io_in(lane), .serial_io_out(out), .serial_io_oe(oe),
        .proto_mode(mode), .busy(busy));

    spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .drv(drv), .line(lane), .oe(oe));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================
    // Expectation and compare helpers
    // ==========================================
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        logic [10:0] p;
        p = a[10:0];
        return (p < 11'd84) ? TBL[8*(83-p) +: 8] : 8'hff;
    endfunction

    task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic run(input logic [23:0] a, input proto_t m, input int nb);
        int k;
        repeat (8) @(negedge clk);
        mode = m;
        host.frame(OP_DISCOVERY, a, m, nb * ((m == PROTO_QUAD) ? 2 : (m == PROTO_DUAL) ? 4 : 8));
        check("byte count", nb[7:0], 8'(host.rx_q.size()));
        for (k = 0; k < nb; k++) begin
            check("table byte", exp_byte(a + 24'(k)), host.rx_q[k]);
        end
    endtask

    task automatic end_sim;
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        end_sim;
    end

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        seed = 32'h7ca34018;
        err_count = 0;
        checks = 0;
        sys_rst = 1'b1;
        mode = PROTO_EXT;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        run(24'h0, PROTO_EXT, 84);
        run(24'h0, PROTO_DUAL, 84);
        run(24'h0, PROTO_QUAD, 84);
        run(24'hfff7fe, PROTO_QUAD, 4);
        // Strap moves only once the lanes have been released
        repeat (8) @(negedge clk);
        mode = PROTO_EXT;
        host.frame(8'ha5, 24'h0, PROTO_EXT, 16);
        check("foreign opcode lanes", 8'h0, {7'h0, host.saw_oe});
        host.frame(OP_DISCOVERY, 24'h31, PROTO_EXT, 3);
        check("aborted byte count", 8'h0, 8'(host.rx_q.size()));
        check("aborted frame lanes", 8'h1, {7'h0, host.saw_oe});
        repeat (6) @(negedge clk);
        check("lanes after abort", 8'h0, {4'h0, oe});
        run(24'h31, PROTO_EXT, 2);
        for (i = 0; i < 20; i++) begin
            run(24'($random(seed)), proto_t'(($random(seed) & 32'hff) % 3),
                1 + ($random(seed) & 3));
        end
        end_sim;
    end
endmodule

`default_nettype wire
